// *** pkg/aucfg_pkg.sv ***
// package: register map, field layout, reset values, types for the arbiter/window config block
package aucfg_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_ARB = 8'h40;
    localparam logic [7:0] ADDR_UPCTL = 8'h48;
    localparam logic [7:0] ADDR_HSW = 8'h4c;
    localparam logic [7:0] ADDR_WIN = 8'h50;
    localparam logic [7:0] ADDR_BASE_HI = 8'h54;
    localparam logic [7:0] ADDR_LIMIT_HI = 8'h58;
    // ****************************************
    // field positions
    // ****************************************
    localparam int ARB_PRIO_LSB = 16;
    localparam int ARB_PRIO_MSB = 23;
    localparam int ARB_BRIDGE_HI = 25;
    localparam int ARB_PARK = 26;
    localparam int UP_WIN_EN = 16;
    localparam int UP_PREFETCH = 17;
    localparam int HSW_SLOT_MSB = 27;
    localparam int HSW_PRE_LSB = 28;
    localparam int HSW_PRE_MSB = 30;
    localparam int HSW_PRE_OFF = 31;
    localparam int WIN_BCAP_LSB = 0;
    localparam int WIN_BCAP_MSB = 3;
    localparam int WIN_BASE_LSB = 4;
    localparam int WIN_BASE_MSB = 15;
    localparam int WIN_LCAP_LSB = 16;
    localparam int WIN_LCAP_MSB = 19;
    localparam int WIN_LIMIT_LSB = 20;
    localparam int WIN_LIMIT_MSB = 31;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] ARB_PRIO_RST = 8'h00;
    localparam logic ARB_BRIDGE_HI_RST = 1'b1;
    localparam logic [27:0] HSW_SLOT_RST = 28'h0003a98;
    localparam logic [31:0] WIN_LIMIT_RST = 32'h000fffff;
    localparam logic [11:0] WIN_BASE_RST = 12'h000;
    localparam logic [3:0] WIN_CAP = 4'h1;
    // ****************************************
    // arbiter sizes and preemption counts
    // ****************************************
    localparam int NUM_REQ = 8;
    localparam int BRIDGE_IDX = 8;
    localparam int LOW_SLOT = 9;
    localparam logic [7:0] PRE_CLK_8 = 8'h08;
    localparam logic [7:0] PRE_CLK_16 = 8'h10;
    localparam logic [7:0] PRE_CLK_32 = 8'h20;
    localparam logic [7:0] PRE_CLK_64 = 8'h40;
    localparam logic [7:0] PRE_CLK_128 = 8'h80;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } aucfg_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } aucfg_apb_rsp_t;

    typedef enum logic [1:0] {
        ARB_PARKED = 2'b01,
        ARB_OWNED = 2'b10
    } aucfg_arb_state_t;
endpackage : aucfg_pkg

// *** core/aucfg_top.sv ***
// arbiter and upstream window configuration registers with secondary arbiter and window decode
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// What this block does
// - one priority bit per request input, reset low
// - bridge own port priority bit, resets high
// - park bit: last master or bridge port
// - reserved bits read zero, ignore writes
// - window enable limits upstream forwarding range
// - prefetchable select bit, resets zero
// - 28-bit hot-swap slot, reset 0003A98h
// - preempt delay codes 8 to 128 clocks
// - preempt disable bit, preemption on at reset
// - capability nibbles read one
// - 12-bit window base field, reset zero
// - 12-bit window limit field
// - base upper 32 address bits register
// - limit upper 32 address bits register
module aucfg_top
    import aucfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire aucfg_apb_req_t apb_in,
    output aucfg_apb_rsp_t apb_out,
    input wire logic [NUM_REQ-1:0] first_secondary_request_lines_in,
    input wire logic bridge_req_in,
    output logic [NUM_REQ:0] grant_out,
    input wire logic up_valid_in,
    input wire logic [63:0] up_addr_in,
    input wire logic dn_hit_in,
    output logic up_claim_out,
    output logic up_prefetch_out,
    output logic [27:0] hotswap_slot_out
);
    // ****************************************
    // configuration state
    // ****************************************
    logic [7:0] prio_reg;
    logic bridge_hi_reg;
    logic park_bridge_reg;
    logic win_en_reg;
    logic prefetch_reg;
    logic [27:0] slot_reg;
    logic [2:0] pre_code_reg;
    logic pre_off_reg;
    logic [11:0] base_reg;
    logic [11:0] limit_reg;
    logic [31:0] base_hi_reg;
    logic [31:0] limit_hi_reg;
    logic ready_reg;
    logic slverr_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;
    logic hit;
    logic sel_acc;
    logic wr_fire;

    // ****************************************
    // apb slave: one wait state, registered answer
    // ****************************************
    assign sel_acc = apb_in.psel & apb_in.penable;
    assign wr_fire = sel_acc & ready_reg & apb_in.pwrite;

    // read decode, reserved bits stay zero
    always_comb begin
        rd_mux = 32'h0;
        hit = 1'b1;
        unique case (apb_in.paddr)
            ADDR_ARB: begin
                rd_mux[ARB_PRIO_MSB:ARB_PRIO_LSB] = prio_reg;
                rd_mux[ARB_BRIDGE_HI] = bridge_hi_reg;
                rd_mux[ARB_PARK] = park_bridge_reg;
            end
            ADDR_UPCTL: begin
                rd_mux[UP_WIN_EN] = win_en_reg;
                rd_mux[UP_PREFETCH] = prefetch_reg;
            end
            ADDR_HSW: begin
                rd_mux[HSW_SLOT_MSB:0] = slot_reg;
                rd_mux[HSW_PRE_MSB:HSW_PRE_LSB] = pre_code_reg;
                rd_mux[HSW_PRE_OFF] = pre_off_reg;
            end
            ADDR_WIN: begin
                rd_mux[WIN_BCAP_MSB:WIN_BCAP_LSB] = WIN_CAP;
                rd_mux[WIN_BASE_MSB:WIN_BASE_LSB] = base_reg;
                rd_mux[WIN_LCAP_MSB:WIN_LCAP_LSB] = WIN_CAP;
                rd_mux[WIN_LIMIT_MSB:WIN_LIMIT_LSB] = limit_reg;
            end
            ADDR_BASE_HI: rd_mux = base_hi_reg;
            ADDR_LIMIT_HI: rd_mux = limit_hi_reg;
            default: hit = 1'b0;
        endcase
    end

    // answer handshake and read data capture
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_reg <= 1'b0;
            slverr_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ready_reg <= sel_acc & ~ready_reg;
            slverr_reg <= sel_acc & ~ready_reg & ~hit;
            if (sel_acc && !ready_reg) begin
                rdata_reg <= apb_in.pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    assign apb_out = '{pready: ready_reg, pslverr: slverr_reg, prdata: rdata_reg};

    // register writes; reserved positions have no storage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prio_reg <= ARB_PRIO_RST;
            bridge_hi_reg <= ARB_BRIDGE_HI_RST;
            park_bridge_reg <= 1'b0;
            win_en_reg <= 1'b0;
            prefetch_reg <= 1'b0;
            slot_reg <= HSW_SLOT_RST;
            pre_code_reg <= 3'h0;
            pre_off_reg <= 1'b0;
            base_reg <= WIN_BASE_RST;
            limit_reg <= WIN_LIMIT_RST[WIN_LIMIT_MSB:WIN_LIMIT_LSB];
            base_hi_reg <= 32'h0;
            limit_hi_reg <= 32'h0;
        end else if (wr_fire) begin
            unique case (apb_in.paddr)
                ADDR_ARB: begin
                    prio_reg <= apb_in.pwdata[ARB_PRIO_MSB:ARB_PRIO_LSB];
                    bridge_hi_reg <= apb_in.pwdata[ARB_BRIDGE_HI];
                    park_bridge_reg <= apb_in.pwdata[ARB_PARK];
                end
                ADDR_UPCTL: begin
                    win_en_reg <= apb_in.pwdata[UP_WIN_EN];
                    prefetch_reg <= apb_in.pwdata[UP_PREFETCH];
                end
                ADDR_HSW: begin
                    slot_reg <= apb_in.pwdata[HSW_SLOT_MSB:0];
                    pre_code_reg <= apb_in.pwdata[HSW_PRE_MSB:HSW_PRE_LSB];
                    pre_off_reg <= apb_in.pwdata[HSW_PRE_OFF];
                end
                ADDR_WIN: begin
                    base_reg <= apb_in.pwdata[WIN_BASE_MSB:WIN_BASE_LSB];
                    limit_reg <= apb_in.pwdata[WIN_LIMIT_MSB:WIN_LIMIT_LSB];
                end
                ADDR_BASE_HI: base_hi_reg <= apb_in.pwdata;
                ADDR_LIMIT_HI: limit_hi_reg <= apb_in.pwdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // upstream window decode
    // ****************************************
    logic [63:0] win_lo;
    logic [63:0] win_hi;
    logic in_win;
    logic claim_reg;
    // unprogrammed low bits: zeros for base, ones for limit
    assign win_lo = {base_hi_reg, base_reg, 20'h00000};
    assign win_hi = {limit_hi_reg, limit_reg, 20'hfffff};
    assign in_win = (up_addr_in >= win_lo) && (up_addr_in <= win_hi);

    // claim one cycle after the address is offered
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            claim_reg <= 1'b0;
        end else begin
            claim_reg <= up_valid_in & (win_en_reg ? in_win : ~dn_hit_in);
        end
    end

    assign up_claim_out = claim_reg;
    assign up_prefetch_out = prefetch_reg;
    assign hotswap_slot_out = slot_reg;

    // ****************************************
    // secondary arbiter
    // ****************************************
    logic [NUM_REQ-1:0] req_s1_reg;
    logic [NUM_REQ-1:0] req_s2_reg;

    // request pins come from outside: two flops before use
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_s1_reg <= '0;
            req_s2_reg <= '0;
        end else begin
            req_s1_reg <= first_secondary_request_lines_in;
            req_s2_reg <= req_s1_reg;
        end
    end

    // first set bit after last, wrapping over n slots
    function automatic logic [3:0] rr_pick(input logic [9:0] vec, input logic [3:0] last,
                                           input int n);
        logic [3:0] pick;
        int k;
        pick = last;
        for (int i = 10; i >= 1; i--) begin
            k = (int'(last) + i) % n;
            if (i <= n && vec[k]) begin
                pick = 4'(k);
            end
        end
        return pick;
    endfunction : rr_pick

    aucfg_arb_state_t state_reg;
    logic [NUM_REQ:0] grant_reg;
    logic [3:0] owner_reg;
    logic [3:0] hi_ptr_reg;
    logic [3:0] lo_ptr_reg;
    logic [7:0] pre_cnt_reg;
    logic [NUM_REQ:0] reqv;
    logic [NUM_REQ:0] hi_mask;
    logic [9:0] slots;
    logic [3:0] hslot;
    logic [3:0] winner;
    logic [3:0] park_idx;
    logic [7:0] pre_limit;
    logic others;

    assign reqv = {bridge_req_in, req_s2_reg};
    assign hi_mask = {bridge_hi_reg, prio_reg};
    // high members plus one slot standing for the whole low group
    assign slots = {|(reqv & ~hi_mask), reqv & hi_mask};
    assign hslot = rr_pick(slots, hi_ptr_reg, LOW_SLOT + 1);
    assign winner = (hslot == 4'(LOW_SLOT)) ?
        rr_pick({1'b0, reqv & ~hi_mask}, lo_ptr_reg, NUM_REQ + 1) : hslot;
    assign park_idx = park_bridge_reg ? 4'(BRIDGE_IDX) : owner_reg;
    assign others = |(reqv & ~grant_reg);

    // preemption delay decode; unused codes fall back to 32
    always_comb begin
        case (pre_code_reg)
            3'h1: pre_limit = PRE_CLK_8;
            3'h2: pre_limit = PRE_CLK_16;
            3'h3: pre_limit = PRE_CLK_64;
            3'h4: pre_limit = PRE_CLK_128;
            default: pre_limit = PRE_CLK_32;
        endcase
    end

    // grant, rotation pointers and preemption timer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ARB_PARKED;
            grant_reg <= '0;
            owner_reg <= 4'(BRIDGE_IDX);
            hi_ptr_reg <= 4'h0;
            lo_ptr_reg <= 4'h0;
            pre_cnt_reg <= 8'h00;
        end else begin
            pre_cnt_reg <= 8'h00;
            unique case (state_reg)
                ARB_PARKED: begin
                    grant_reg <= (NUM_REQ+1)'(1) << park_idx;
                    if (|reqv) begin
                        state_reg <= ARB_OWNED;
                    end
                end
                ARB_OWNED: begin
                    if (!reqv[owner_reg] || (pre_cnt_reg == pre_limit - 8'h01)) begin
                        state_reg <= ARB_PARKED;
                        grant_reg <= (NUM_REQ+1)'(1) << park_idx;
                    end else if (!pre_off_reg && others) begin
                        pre_cnt_reg <= pre_cnt_reg + 8'h01;
                    end
                end
                default: state_reg <= ARB_PARKED;
            endcase
            // a new owner is chosen on any request while parked
            if (state_reg == ARB_PARKED && |reqv) begin
                grant_reg <= (NUM_REQ+1)'(1) << winner;
                owner_reg <= winner;
                hi_ptr_reg <= hslot;
                if (hslot == 4'(LOW_SLOT)) begin
                    lo_ptr_reg <= winner;
                end
            end
        end
    end

    assign grant_out = grant_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_wr(logic [7:0] a);
        apb_in.psel && apb_in.penable && apb_in.pwrite && ready_reg && apb_in.paddr == a;
    endsequence
    sequence s_rd_issue(logic [7:0] a);
        apb_in.psel && apb_in.penable && !apb_in.pwrite && !ready_reg && apb_in.paddr == a;
    endsequence

    property p_arb_write;
        s_wr(ADDR_ARB) |=> prio_reg == $past(apb_in.pwdata[23:16])
            && bridge_hi_reg == $past(apb_in.pwdata[25]);
    endproperty
    a_arb_write: assert property (p_arb_write) else $error("arbiter control write lost");
    property p_arb_resv;
        s_rd_issue(ADDR_ARB) |=> apb_out.pready && apb_out.prdata[24] == 1'b0
            && apb_out.prdata[31:27] == 5'h0;
    endproperty
    a_arb_resv: assert property (p_arb_resv) else $error("arbiter reserved bits nonzero");
    property p_up_resv;
        s_rd_issue(ADDR_UPCTL) |=> apb_out.prdata[31:18] == 14'h0;
    endproperty
    a_up_resv: assert property (p_up_resv) else $error("upstream reserved bits nonzero");
    property p_cap;
        s_rd_issue(ADDR_WIN) |=> apb_out.prdata[3:0] == 4'h1 && apb_out.prdata[19:16] == 4'h1;
    endproperty
    a_cap: assert property (p_cap) else $error("capability nibble not one");
    property p_park_bridge;
        (state_reg == ARB_PARKED && park_bridge_reg && !(|reqv))[*2]
            |-> grant_out == 9'h100;
    endproperty
    a_park_bridge: assert property (p_park_bridge) else $error("idle bus not on bridge");
    property p_claim_win;
        up_valid_in && win_en_reg && up_addr_in >= {base_hi_reg, base_reg, 20'h00000}
            && up_addr_in <= {limit_hi_reg, limit_reg, 20'hfffff} |=> up_claim_out;
    endproperty
    a_claim_win: assert property (p_claim_win) else $error("window hit not claimed");
    property p_claim_off;
        up_valid_in && !win_en_reg |=> up_claim_out == !$past(dn_hit_in);
    endproperty
    a_claim_off: assert property (p_claim_off) else $error("disabled window claim wrong");
    property p_pre_bound;
        state_reg == ARB_OWNED |-> pre_cnt_reg < pre_limit;
    endproperty
    a_pre_bound: assert property (p_pre_bound) else $error("preempt timer overran");
    property p_pre_off;
        pre_off_reg && $past(pre_off_reg) |-> pre_cnt_reg == 8'h00;
    endproperty
    a_pre_off: assert property (p_pre_off) else $error("preempt counted while off");
    property p_slot_write;
        s_wr(ADDR_HSW) |=> hotswap_slot_out == $past(apb_in.pwdata[27:0])
            && up_prefetch_out == $past(up_prefetch_out);
    endproperty
    a_slot_write: assert property (p_slot_write) else $error("hot-swap slot write lost");
    property p_hi_write;
        s_wr(ADDR_BASE_HI) |=> base_hi_reg == $past(apb_in.pwdata)
            && limit_hi_reg == $past(limit_hi_reg);
    endproperty
    a_hi_write: assert property (p_hi_write) else $error("base upper write wrong");
    property p_onehot;
        $onehot0(grant_out);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one grant");
endmodule : aucfg_top

// *** verif/aucfg_master_model.sv ***
// behavioural secondary bus masters: request, use the bus for a while, release
`timescale 1ns/100ps
module aucfg_master_model
    import aucfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [NUM_REQ-1:0] want_in,
    input wire logic [15:0] hold_in,
    input wire logic [NUM_REQ:0] grant_in,
    output logic [NUM_REQ-1:0] req_out,
    output logic [NUM_REQ-1:0][15:0] tally_out
);
    logic [NUM_REQ-1:0][15:0] use_cnt;
    logic [NUM_REQ-1:0] gap;

    // each master holds its request until it has used the bus hold_in cycles
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_out <= '0;
            use_cnt <= '0;
            gap <= '0;
            tally_out <= '0;
        end else begin
            for (int i = 0; i < NUM_REQ; i++) begin
                if (gap[i]) begin
                    gap[i] <= 1'b0; // one idle cycle between tenures
                end else if (req_out[i] && grant_in[i]) begin
                    if (use_cnt[i] == 16'h0) begin
                        tally_out[i] <= tally_out[i] + 16'h1;
                    end
                    use_cnt[i] <= use_cnt[i] + 16'h1;
                    if (use_cnt[i] + 16'h1 >= hold_in) begin
                        req_out[i] <= 1'b0;
                        use_cnt[i] <= 16'h0;
                        gap[i] <= 1'b1;
                    end
                end else begin
                    req_out[i] <= want_in[i];
                end
            end
        end
    end
endmodule : aucfg_master_model

// *** verif/tb_top.sv ***
// self-checking testbench for the arbiter and upstream window configuration block
`timescale 1ns/100ps
module tb_top;
    import aucfg_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    aucfg_apb_req_t apb_q = '0;
    aucfg_apb_rsp_t apb_rsp;
    logic [NUM_REQ-1:0] want = '0;
    logic [15:0] hold = 16'h0004;
    logic [NUM_REQ-1:0] reqs;
    logic [NUM_REQ-1:0][15:0] tally;
    logic [NUM_REQ:0] grant;
    logic bridge_req = 1'b0;
    logic up_valid = 1'b0;
    logic [63:0] up_addr = '0;
    logic dn_hit = 1'b0;
    logic claim;
    logic pref;
    logic [27:0] slot;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] map_a [6] = '{ADDR_ARB, ADDR_UPCTL, ADDR_HSW, ADDR_WIN, ADDR_BASE_HI, ADDR_LIMIT_HI};
    logic [31:0] rst_v [6] = '{32'h02000000, 32'h0, 32'h00003a98, 32'h00010001, 32'h0, 32'h0};
    logic [31:0] ones_v [6] = '{32'h06ff0000, 32'h00030000, 32'hffffffff, 32'hfff1fff1,
                                32'hffffffff, 32'hffffffff};
    int pre_lim [5] = '{32, 8, 16, 64, 128};

    // ****************************************
    // clock, design, partner
    // ****************************************
    always #5 clk_in = ~clk_in;

    aucfg_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .apb_in(apb_q), .apb_out(apb_rsp),
        .first_secondary_request_lines_in(reqs), .bridge_req_in(bridge_req), .grant_out(grant),
        .up_valid_in(up_valid), .up_addr_in(up_addr), .dn_hit_in(dn_hit), .up_claim_out(claim),
        .up_prefetch_out(pref), .hotswap_slot_out(slot));

    aucfg_master_model model_u (.clk_in(clk_in), .rst_in(rst_in), .want_in(want),
        .hold_in(hold), .grant_in(grant), .req_out(reqs), .tally_out(tally));

    // ****************************************
    // shared tasks
    // ****************************************
    task stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer: setup, access until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge clk_in);
        apb_q <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        apb_q.penable <= 1'b1;
        // pready is read before this edge's updates land, as the slave sees it
        do begin
            @(posedge clk_in);
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_q <= '0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk(32'(e), 32'h0);
    endtask : rdc

    task wgr(input int i);
        int n;
        n = 0;
        while (grant[i] !== 1'b1 && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        chk(32'(grant[i]), 32'h1);
        @(posedge clk_in);
    endtask : wgr

    task probe(input logic v, input logic [63:0] a, input logic dn, input logic exp);
        @(posedge clk_in);
        up_valid <= v;
        up_addr <= a;
        dn_hit <= dn;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk(32'(claim), 32'(exp));
    endtask : probe

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs();
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 6; i++) begin
            rdc(map_a[i], rst_v[i]);
        end
        chk(32'(slot), 32'h00003a98);
        apb(1'b0, 8'h44, 32'h0, q, e);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(map_a[i], 32'hffffffff);
        end
        for (int i = 0; i < 6; i++) begin
            rdc(map_a[i], ones_v[i]);
        end
        chk(32'(slot), 32'h0fffffff);
        chk(32'(pref), 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(map_a[i], 32'h0);
        end
        rdc(ADDR_WIN, 32'h00010001);
        chk(32'(pref), 32'h0);
        $display("done: register access");
    endtask : t_regs

    task t_window();
        wr(ADDR_BASE_HI, 32'h1);
        wr(ADDR_LIMIT_HI, 32'h1);
        wr(ADDR_WIN, 32'h00200010);
        wr(ADDR_UPCTL, 32'h00010000);
        probe(1'b1, 64'h0000000100100000, 1'b0, 1'b1);
        probe(1'b1, 64'h00000001002fffff, 1'b0, 1'b1);
        probe(1'b1, 64'h00000001000fffff, 1'b0, 1'b0);
        probe(1'b1, 64'h0000000100300000, 1'b0, 1'b0);
        probe(1'b1, 64'h0000000000150000, 1'b0, 1'b0);
        probe(1'b1, 64'h0000000200100000, 1'b0, 1'b0);
        wr(ADDR_UPCTL, 32'h0);
        probe(1'b1, 64'h0000000300000000, 1'b0, 1'b1);
        probe(1'b1, 64'h0000000300000000, 1'b1, 1'b0);
        probe(1'b0, 64'h0000000300000000, 1'b0, 1'b0);
        $display("done: upstream window");
    endtask : t_window

    task t_park();
        want <= 8'h08;
        wgr(3);
        want <= 8'h00;
        repeat (12) @(posedge clk_in);
        chk(32'(grant), 32'h008);
        wr(ADDR_ARB, 32'h04000000);
        repeat (4) @(posedge clk_in);
        chk(32'(grant), 32'h100);
        wr(ADDR_ARB, 32'h0);
        $display("done: parking");
    endtask : t_park

    // bridge port requester in the high group, then idle parks on it as last master
    task t_bridge();
        wr(ADDR_ARB, 32'h02000000);
        bridge_req <= 1'b1;
        wgr(BRIDGE_IDX);
        bridge_req <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk(32'(grant), 32'h100);
        $display("done: bridge port");
    endtask : t_bridge

    // one high member against two low members sharing the low slot
    task t_prio(input logic [31:0] arb, input int hi, input int lo);
        logic [15:0] bh;
        logic [15:0] bl;
        wr(ADDR_HSW, 32'h80000000);
        wr(ADDR_ARB, arb);
        bh = tally[hi];
        bl = tally[lo];
        hold <= 16'h0003;
        want <= 8'h64;
        repeat (300) @(posedge clk_in);
        want <= 8'h00;
        repeat (20) @(posedge clk_in);
        chk(32'((tally[hi] - bh) > (tally[lo] - bl)), 32'h1);
        $display("done: priority groups");
    endtask : t_prio

    task t_preempt();
        int n;
        for (int k = 0; k < 5; k++) begin
            wr(ADDR_HSW, 32'(k) << 28);
            hold <= 16'd1000;
            want <= 8'h01;
            wgr(0);
            want <= 8'h03;
            n = 0;
            while (grant[0] === 1'b1 && n < 200) begin
                @(posedge clk_in);
                n++;
            end
            chk(32'(n >= pre_lim[k] && n <= pre_lim[k] + 8), 32'h1);
            hold <= 16'h0002;
            want <= 8'h00;
            repeat (20) @(posedge clk_in);
        end
        wr(ADDR_HSW, 32'h90000000);
        hold <= 16'd1000;
        want <= 8'h01;
        wgr(0);
        want <= 8'h03;
        repeat (150) @(posedge clk_in);
        chk(32'(grant), 32'h001);
        hold <= 16'h0002;
        want <= 8'h00;
        repeat (20) @(posedge clk_in);
        $display("done: preemption");
    endtask : t_preempt

    // ****************************************
    // main sequence and hang guard
    // ****************************************
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("[FAIL] %0t run did not finish", $time);
            stop_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_window();
        t_park();
        t_bridge();
        t_prio(32'h00040000, 2, 5);
        t_prio(32'h00200000, 5, 2);
        t_preempt();
        stop_test();
    end
endmodule : tb_top
